// ==== src/sgc_params.svh ====
// Register offsets, field positions, reset values for the global config bank
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH
`define SGC_OFF_CONFIG     12'h800
`define SGC_OFF_TEST       12'h802
`define SGC_OFF_LEVEL      12'h804
`define SGC_OFF_VECTOR     12'h805
`define SGC_BIT_STOP       15
`define SGC_BIT_FREEZE     14
`define SGC_BIT_FRZ_RSVD   13
`define SGC_BIT_SUPERVISOR_SELECT       7
`define SGC_ARB_MSB        3
`define SGC_BIT_SCAN_SEL   3
`define SGC_BIT_SCAN_EN    1
`define SGC_LEVEL_MSB      2
`define SGC_CONFIG_MASK    16'hC08F
`define SGC_TEST_MASK      16'h000A
`define SGC_CONFIG_RESET   16'h0080
`define SGC_TEST_RESET     16'h0000
`define SGC_LEVEL_RESET    3'h0
`define SGC_VECTOR_RESET   8'h0F
`define SGC_ARB_NONE       4'h0
`endif

// ==== src/sgc_pkg.sv ====
// Types shared by the global config bank
package sgc_pkg;
  typedef enum logic [2:0] {
    SGC_RUN    = 3'b001,
    SGC_HALTNG = 3'b010,
    SGC_FROZEN = 3'b100
  } sgc_frz_t;
endpackage

// ==== src/sgc_freeze.sv ====
// Freeze sequencer: halt on transfer boundary, resume when freeze drops
`timescale 1ns/1ps
`include "sgc_params.svh"
module sgc_freeze
  import sgc_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_reset,
  input  wire logic i_enable,
  input  wire logic i_freeze_response,
  input  wire logic i_freeze,
  input  wire logic i_transfer_boundary,
  output logic      o_freeze_halt
);
  typedef struct packed {
    sgc_frz_t state;
    logic     halt;
  } sgc_fz_t;
  sgc_fz_t cur, next_cur;

  // Wait for a boundary, then hold until freeze is negated
  always_comb begin
    next_cur = cur;
    case (cur.state)
      SGC_RUN: begin
        if (i_freeze && i_freeze_response) begin
          next_cur.state = i_transfer_boundary ? SGC_FROZEN : SGC_HALTNG;
        end
      end
      SGC_HALTNG: begin
        if (!i_freeze) begin
          next_cur.state = SGC_RUN;
        end else if (i_transfer_boundary) begin
          next_cur.state = SGC_FROZEN;
        end
      end
      SGC_FROZEN: begin
        if (!i_freeze) begin
          next_cur.state = SGC_RUN;
        end
      end
      default: next_cur.state = SGC_RUN;
    endcase
    next_cur.halt = (next_cur.state == SGC_FROZEN);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cur <= '{state: SGC_RUN, halt: 1'b0};
    end else if (i_enable) begin
      cur <= next_cur;
    end
  end

  assign o_freeze_halt = cur.halt;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  frz_needs_bit_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_enable && cur.state == SGC_RUN && !i_freeze_response
      |=> cur.state == SGC_RUN)
    else $error("freeze taken while freeze response is off");
  frz_release_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_enable && cur.state == SGC_FROZEN && !i_freeze |=> !o_freeze_halt)
    else $error("frozen module did not resume");
  frz_cov_c: cover property (@(posedge i_clock) disable iff (i_reset)
    cur.state == SGC_HALTNG ##[1:20] cur.state == SGC_FROZEN);
endmodule

// ==== src/sgc_top.sv ====
// Global configuration, test and interrupt registers of the serial module
//
// How it works
// - configuration register writes accepted only from supervisor accesses.
// - stop bit 15 set gates the module clock; clear runs normally.
// - while stopped only configuration reads are valid; writes still apply.
// - stop bit cleared by a processor write or by reset.
// - freeze bit 14 with bus freeze halts at the next transfer boundary.
// - frozen module holds its pins and resumes when freeze drops.
// - configuration bit 13 is reserved, no function.
// - supervisor select set puts registers in supervisor space; no ack users.
// - supervisor select clear acks all; user access to supervisor unmapped.
// - arbitration number contends against same-level interrupts, unique.
// - arbitration resets to zero, then no arbitration; software sets 1..F.
// - test register accessed only in test mode.
// - test bit 3 picks delay scan path, else baud clock path.
// - test bit 1 enables scan path drive, clear disables it.
// - level register accessible only in supervisor mode.
// - level applies to all serial interrupts; zero disables, seven highest.
// - vector resets to 0F and is supplied until written.
// - acknowledge drives vector bits 7..1; bit 0 comes from the bus unit.
// - vector bit zero ignores writes and reads as one.
`timescale 1ns/1ps
`include "sgc_params.svh"
module sgc_top
  import sgc_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_enable,
  input  wire logic        i_access,
  input  wire logic        i_write,
  input  wire logic        i_supervisor,
  input  wire logic [11:0] i_address,
  input  wire logic [1:0]  i_byte_enable,
  input  wire logic [15:0] i_write_data,
  input  wire logic        i_test_mode,
  input  wire logic        i_freeze,
  input  wire logic        i_transfer_boundary,
  input  wire logic        i_halt_acknowledge_flag,
  input  wire logic        i_irq_pending,
  input  wire logic        i_interrupt_acknowledge_cycle,
  input  wire logic [2:0]  i_interrupt_acknowledge_cycle_level,
  input  wire logic [3:0]  i_interrupt_acknowledge_cycle_arb_best,
  output logic             o_address_acknowledge,
  output logic [15:0]      o_read_data,
  output logic             o_clock_gate_stop,
  output logic             o_freeze_halt,
  output logic             o_scan_path_select,
  output logic             o_test_scan_enable,
  output logic [2:0]       o_irq_level,
  output logic [3:0]       o_arb_request,
  output logic             o_interrupt_acknowledge_cycle_hit,
  output logic [7:0]       o_interrupt_acknowledge_cycle_data
);
  import sgc_pkg::*;

  typedef struct packed {
    logic [15:0] config_r;
    logic [15:0] test_r;
    logic [2:0]  level_r;
    logic [7:1]  vector_r;
    logic [15:0] rdata;
    logic [7:0]  interrupt_acknowledge_cycle_data;
    logic        interrupt_acknowledge_cycle_hit;
  } sgc_state_t;
  sgc_state_t cur, next_cur;

  // Decode helpers, used by read and write paths
  function automatic logic sgc_hit(input logic [11:0] a,
                                   input logic [11:0] off);
    sgc_hit = (a[11:1] == off[11:1]);
  endfunction
  function automatic logic [15:0] sgc_merge(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be,
                                            input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
    sgc_merge = (old & ~lanes) | (wd & lanes);
  endfunction

  logic        supervisor_select;
  logic        stopped;
  logic        hit_cfg;
  logic        hit_tst;
  logic        hit_lv;
  logic        sup_only;
  logic        acked;
  logic        granted;
  logic [15:0] lvvec_word;
  logic        arb_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and access permission
  assign supervisor_select      = cur.config_r[`SGC_BIT_SUPERVISOR_SELECT];
  assign stopped   = cur.config_r[`SGC_BIT_STOP];
  assign hit_cfg   = sgc_hit(i_address, `SGC_OFF_CONFIG);
  assign hit_tst   = sgc_hit(i_address, `SGC_OFF_TEST);
  assign hit_lv    = sgc_hit(i_address, `SGC_OFF_LEVEL);
  // Config and level are supervisor only; test needs test mode
  assign sup_only  = hit_cfg | hit_lv;
  // User access never acked while supervisor select is set
  assign acked     = i_access && (hit_cfg | hit_tst | hit_lv)
                     && (i_supervisor || !supervisor_select);
  assign granted   = acked && (i_supervisor || !sup_only)
                     && (!hit_tst || i_test_mode);
  // Level sits in the high byte, vector in the low byte
  assign lvvec_word = {5'h00, cur.level_r, cur.vector_r, 1'b1};
  assign arb_valid  = cur.config_r[`SGC_ARB_MSB:0] != `SGC_ARB_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register writes, read data, acknowledge response
  always_comb begin
    next_cur = cur;
    next_cur.rdata    = 16'h0000;
    next_cur.interrupt_acknowledge_cycle_hit = 1'b0;
    next_cur.interrupt_acknowledge_cycle_data = 8'h00;
    if (granted && i_write) begin
      if (hit_cfg) begin
        // Only implemented bits take the write; stop clears by write
        next_cur.config_r = sgc_merge(cur.config_r, i_write_data,
                                      i_byte_enable,
                                      `SGC_CONFIG_MASK);
      end
      if (hit_tst) begin
        next_cur.test_r = sgc_merge(cur.test_r, i_write_data, i_byte_enable,
                                    `SGC_TEST_MASK);
      end
      if (hit_lv && i_byte_enable[1]) begin
        next_cur.level_r = i_write_data[8+`SGC_LEVEL_MSB:8];
      end
      // Bit zero of the vector is not stored
      if (hit_lv && i_byte_enable[0]) begin
        next_cur.vector_r = i_write_data[7:1];
      end
    end
    if (granted && !i_write) begin
      // While stopped only the config register is a guaranteed read
      if (hit_cfg) begin
        next_cur.rdata = cur.config_r;
      end else if (!stopped) begin
        if (hit_tst) begin
          next_cur.rdata = cur.test_r;
        end else begin
          next_cur.rdata = lvvec_word;
        end
      end
    end
    // Win the acknowledge only with a live level and a nonzero number
    if (i_interrupt_acknowledge_cycle && i_irq_pending && arb_valid
        && cur.level_r != 3'h0 && i_interrupt_acknowledge_cycle_level == cur.level_r
        && i_interrupt_acknowledge_cycle_arb_best == cur.config_r[`SGC_ARB_MSB:0]) begin
      next_cur.interrupt_acknowledge_cycle_hit  = 1'b1;
      next_cur.interrupt_acknowledge_cycle_data = {cur.vector_r, 1'b0};
    end
  end

  // One register stage; clock enable freezes everything
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cur.config_r  <= `SGC_CONFIG_RESET;
      cur.test_r    <= `SGC_TEST_RESET;
      cur.level_r   <= `SGC_LEVEL_RESET;
      cur.vector_r  <= 7'(`SGC_VECTOR_RESET >> 1);
      cur.rdata     <= 16'h0000;
      cur.interrupt_acknowledge_cycle_data <= 8'h00;
      cur.interrupt_acknowledge_cycle_hit  <= 1'b0;
    end else if (i_enable) begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Freeze sequencer
  sgc_freeze u_freeze (
    .i_clock             (i_clock),
    .i_reset             (i_reset),
    .i_enable            (i_enable),
    .i_freeze_response   (cur.config_r[`SGC_BIT_FREEZE]),
    .i_freeze            (i_freeze),
    .i_transfer_boundary (i_transfer_boundary),
    .o_freeze_halt       (o_freeze_halt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; ack is a handshake term, read data from flops
  assign o_address_acknowledge = acked;
  assign o_read_data        = cur.rdata;
  assign o_clock_gate_stop  = stopped;
  assign o_scan_path_select = cur.test_r[`SGC_BIT_SCAN_SEL];
  assign o_test_scan_enable = cur.test_r[`SGC_BIT_SCAN_EN];
  // Level zero means no request at all
  assign o_irq_level   = i_irq_pending ? cur.level_r : 3'h0;
  assign o_arb_request = (i_irq_pending && cur.level_r != 3'h0)
                         ? cur.config_r[`SGC_ARB_MSB:0] : 4'h0;
  assign o_interrupt_acknowledge_cycle_hit    = cur.interrupt_acknowledge_cycle_hit;
  assign o_interrupt_acknowledge_cycle_data   = cur.interrupt_acknowledge_cycle_data;

  // Halt acknowledge is only advisory for software before stopping
  logic unused_halt_ack;
  assign unused_halt_ack = i_halt_acknowledge_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  // Supervisor-only registers and address acknowledge
  user_cfg_write_a: assert property (
    i_enable && i_access && i_write && !i_supervisor && hit_cfg
    |=> $stable(cur.config_r))
    else $error("user write changed config");
  supervisor_select_no_ack_a: assert property (
    i_access && supervisor_select && !i_supervisor |-> !o_address_acknowledge)
    else $error("user access acked with supervisor select");
  open_ack_a: assert property (
    i_access && !supervisor_select && hit_tst |-> o_address_acknowledge)
    else $error("unrestricted access not acked");
  user_read_zero_a: assert property (
    i_enable && i_access && !i_write && !i_supervisor && sup_only
    |=> o_read_data == 16'h0000)
    else $error("user read of supervisor register returned data");
  unmapped_no_ack_a: assert property (
    i_access && !(hit_cfg || hit_tst || hit_lv) |-> !o_address_acknowledge)
    else $error("unmapped address acked");
  level_user_a: assert property (
    i_enable && i_access && i_write && !i_supervisor && hit_lv
    |=> $stable(cur.level_r) && $stable(cur.vector_r))
    else $error("user write changed level or vector");

  // Reserved bits, stop, and accesses while stopped
  rsvd_zero_a: assert property (
    (cur.config_r & ~`SGC_CONFIG_MASK) == 16'h0000)
    else $error("unimplemented config bits set");
  test_rsvd_a: assert property (
    (cur.test_r & ~`SGC_TEST_MASK) == 16'h0000)
    else $error("unimplemented test bits set");
  frz_rsvd_a: assert property (
    i_enable && granted && i_write && hit_cfg
    |=> !cur.config_r[`SGC_BIT_FRZ_RSVD])
    else $error("reserved freeze option stored");
  stop_out_a: assert property (
    o_clock_gate_stop == cur.config_r[`SGC_BIT_STOP])
    else $error("stop output mismatched");
  stop_clear_a: assert property (
    i_enable && granted && i_write && hit_cfg && i_byte_enable[1]
    && !i_write_data[`SGC_BIT_STOP] |=> !o_clock_gate_stop)
    else $error("stop not cleared by write");
  stopped_read_a: assert property (
    i_enable && granted && !i_write && stopped && !hit_cfg
    |=> o_read_data == 16'h0000)
    else $error("unguaranteed read returned data while stopped");
  stopped_write_a: assert property (
    i_enable && granted && i_write && hit_lv && i_byte_enable[1] && stopped
    |=> cur.level_r == $past(i_write_data[8+`SGC_LEVEL_MSB:8]))
    else $error("level write lost while stopped");

  // Test register gating and scan path outputs
  test_gate_a: assert property (
    i_enable && i_access && i_write && hit_tst && !i_test_mode
    |=> $stable(cur.test_r))
    else $error("test written outside test mode");
  scan_sel_wr_a: assert property (
    i_enable && granted && i_write && hit_tst && i_byte_enable[0]
    |=> o_scan_path_select == $past(i_write_data[`SGC_BIT_SCAN_SEL]))
    else $error("scan path select not taken");
  scan_en_wr_a: assert property (
    i_enable && granted && i_write && hit_tst && i_byte_enable[0]
    |=> o_test_scan_enable == $past(i_write_data[`SGC_BIT_SCAN_EN]))
    else $error("scan enable not taken");

  // Interrupt level, vector and acknowledge arbitration
  level_zero_a: assert property (
    cur.level_r == 3'h0 |-> o_irq_level == 3'h0)
    else $error("interrupt raised at level zero");
  level_miss_a: assert property (
    i_enable && i_interrupt_acknowledge_cycle_level != cur.level_r |=> !o_interrupt_acknowledge_cycle_hit)
    else $error("acknowledge won at another level");
  arb_lose_a: assert property (
    i_enable && i_interrupt_acknowledge_cycle_arb_best != cur.config_r[`SGC_ARB_MSB:0]
    |=> !o_interrupt_acknowledge_cycle_hit)
    else $error("acknowledge won by another module");
  no_arb_zero_a: assert property (
    i_enable && cur.config_r[`SGC_ARB_MSB:0] == `SGC_ARB_NONE
    |=> !o_interrupt_acknowledge_cycle_hit)
    else $error("acknowledge won with arbitration zero");
  vec_hold_a: assert property (
    i_enable && !(granted && i_write && hit_lv && i_byte_enable[0])
    |=> $stable(cur.vector_r))
    else $error("vector changed without a write");
  vec_bit0_a: assert property (
    i_enable && i_access && !i_write && hit_lv && granted && !stopped
    |=> o_read_data[0])
    else $error("vector bit zero read as zero");
  interrupt_acknowledge_cycle_vec_a: assert property (
    i_enable && o_interrupt_acknowledge_cycle_hit |-> o_interrupt_acknowledge_cycle_data[0] == 1'b0
      && o_interrupt_acknowledge_cycle_data[7:1] == $past(cur.vector_r))
    else $error("acknowledge vector wrong");

  cfg_wr_c: cover property (i_access && i_write && granted && hit_cfg);
  stop_c:   cover property ($rose(o_clock_gate_stop));
  interrupt_acknowledge_cycle_c:   cover property (o_interrupt_acknowledge_cycle_hit);
  frz_c:    cover property ($rose(o_freeze_halt));
endmodule

// ==== dv/sgc_core_model.sv ====
// Processor-side model: interrupt acknowledge cycles and bus arbitration
`timescale 1ns/1ps
module sgc_core_model (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_start,
  input  wire logic [3:0] i_rival,
  input  wire logic [2:0] i_irq_level,
  input  wire logic [3:0] i_arb_request,
  input  wire logic       i_interrupt_acknowledge_cycle_hit,
  input  wire logic [7:0] i_interrupt_acknowledge_cycle_data,
  output logic            o_interrupt_acknowledge_cycle,
  output logic [2:0]      o_interrupt_acknowledge_cycle_level,
  output logic [3:0]      o_interrupt_acknowledge_cycle_arb_best,
  output logic [7:0]      o_vector
);
  //////////////////////////////////////////////////////////////////////////////
  // One acknowledge cycle per start; idle lines toggle so stale values fail
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_interrupt_acknowledge_cycle          <= 1'b0;
      o_interrupt_acknowledge_cycle_level    <= 3'h0;
      o_interrupt_acknowledge_cycle_arb_best <= 4'h0;
      o_vector        <= 8'h00;
    end else begin
      o_interrupt_acknowledge_cycle       <= i_start;
      o_interrupt_acknowledge_cycle_level <= i_start ? i_irq_level : ~o_interrupt_acknowledge_cycle_level;
      // Highest number wins; the bench keeps rival numbers unique
      o_interrupt_acknowledge_cycle_arb_best <= !i_start ? ~o_interrupt_acknowledge_cycle_arb_best :
        (i_rival > i_arb_request) ? i_rival : i_arb_request;
      // Bus unit supplies bit 0 as one
      if (i_interrupt_acknowledge_cycle_hit) o_vector <= {i_interrupt_acknowledge_cycle_data[7:1], 1'b1};
    end
  end
endmodule

// ==== dv/sgc_top_test.sv ====
// Self-checking bench for the global configuration register bank
`timescale 1ns/1ps
module sgc_top_test;
  import sgc_pkg::*;
  logic        i_clock, i_reset, i_enable, i_access, i_write, i_supervisor;
  logic [11:0] i_address;
  logic [1:0]  i_byte_enable, bed;
  logic [15:0] i_write_data, o_read_data;
  logic        i_test_mode, i_freeze, i_transfer_boundary, i_interrupt_acknowledge_cycle;
  logic        i_halt_acknowledge_flag, i_irq_pending, start;
  logic [2:0]  i_interrupt_acknowledge_cycle_level, o_irq_level;
  logic [3:0]  i_interrupt_acknowledge_cycle_arb_best, o_arb_request, rival;
  logic        o_address_acknowledge, o_clock_gate_stop, o_freeze_halt;
  logic        o_scan_path_select, o_test_scan_enable, o_interrupt_acknowledge_cycle_hit;
  logic [7:0]  o_interrupt_acknowledge_cycle_data, vec;
  logic [15:0] tv [4] = '{16'hFFFF, 16'h0008, 16'h0002, 16'h0000};
  int          n_errors, compares, cycles;
  //////////////////////////////////////////////////////////////////////////////
  sgc_top dut_u (.i_clock, .i_reset, .i_enable, .i_access, .i_write,
    .i_supervisor, .i_address, .i_byte_enable, .i_write_data, .i_test_mode,
    .i_freeze, .i_transfer_boundary, .i_halt_acknowledge_flag, .i_irq_pending,
    .i_interrupt_acknowledge_cycle, .i_interrupt_acknowledge_cycle_level, .i_interrupt_acknowledge_cycle_arb_best, .o_address_acknowledge,
    .o_read_data, .o_clock_gate_stop, .o_freeze_halt, .o_scan_path_select,
    .o_test_scan_enable, .o_irq_level, .o_arb_request, .o_interrupt_acknowledge_cycle_hit,
    .o_interrupt_acknowledge_cycle_data);
  sgc_core_model core_u (.i_clock, .i_reset, .i_start(start), .i_rival(rival),
    .i_irq_level(o_irq_level), .i_arb_request(o_arb_request),
    .i_interrupt_acknowledge_cycle_hit(o_interrupt_acknowledge_cycle_hit), .i_interrupt_acknowledge_cycle_data(o_interrupt_acknowledge_cycle_data), .o_interrupt_acknowledge_cycle(i_interrupt_acknowledge_cycle),
    .o_interrupt_acknowledge_cycle_level(i_interrupt_acknowledge_cycle_level), .o_interrupt_acknowledge_cycle_arb_best(i_interrupt_acknowledge_cycle_arb_best),
    .o_vector(vec));
  //////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling so a hung handshake still ends the run
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One bus access: held for one taken edge, read data checked next cycle
  task automatic acc(input logic w, sv, input logic [11:0] a,
                     input logic [15:0] d, input logic ea,
                     input logic [15:0] er);
    @(posedge i_clock);
    i_access <= 1'b1;
    i_write <= w;
    i_supervisor <= sv;
    i_address <= a;
    i_write_data <= d;
    i_byte_enable <= bed;
    @(posedge i_clock);
    check("ack", o_address_acknowledge, ea);
    i_access <= 1'b0;
    @(posedge i_clock);
    check("read_data", o_read_data, er);
  endtask
  // Acknowledge cycle against a rival module's arbitration number
  task automatic interrupt_acknowledge_cycle_run(input logic [3:0] rv, input logic h,
                          input logic [7:0] ed);
    @(posedge i_clock);
    start <= 1'b1;
    rival <= rv;
    @(posedge i_clock);
    start <= 1'b0;
    repeat (2) @(posedge i_clock);
    check("interrupt_acknowledge_cycle_hit", o_interrupt_acknowledge_cycle_hit, h);
    check("interrupt_acknowledge_cycle_data", o_interrupt_acknowledge_cycle_data, ed);
    @(posedge i_clock);
    if (h) check("vector", vec, {ed[7:1], 1'b1});
  endtask
  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_reset, i_enable, bed} = 4'hF;
    {i_access, i_write, i_supervisor, i_test_mode, i_freeze} = 5'h00;
    {i_transfer_boundary, i_halt_acknowledge_flag, i_irq_pending} = 3'h0;
    {i_address, i_write_data, start, rival} = 33'h0;
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    i_test_mode <= 1'b1;
    acc(0, 1, 12'h800, 16'h0, 1, 16'h0080);
    acc(0, 1, 12'h802, 16'h0, 1, 16'h0000);
    acc(0, 1, 12'h804, 16'h0, 1, 16'h000F);
    acc(0, 0, 12'h800, 16'h0, 0, 16'h0000);
    acc(0, 1, 12'h806, 16'h0, 0, 16'h0000);
    acc(1, 1, 12'h800, 16'h7F7F, 1, 16'h0);
    acc(0, 1, 12'h800, 16'h0, 1, 16'h400F);
    acc(1, 0, 12'h800, 16'h0000, 1, 16'h0);
    acc(0, 0, 12'h800, 16'h0, 1, 16'h0000);
    acc(0, 1, 12'h800, 16'h0, 1, 16'h400F);
    acc(1, 0, 12'h804, 16'h0345, 1, 16'h0);
    acc(0, 0, 12'h804, 16'h0, 1, 16'h0000);
    acc(0, 1, 12'h804, 16'h0, 1, 16'h000F);
    acc(1, 1, 12'h804, 16'hFF44, 1, 16'h0);
    acc(0, 1, 12'h804, 16'h0, 1, 16'h0745);
    bed <= 2'b01;
    acc(1, 1, 12'h804, 16'h0081, 1, 16'h0);
    bed <= 2'b11;
    acc(0, 1, 12'h804, 16'h0, 1, 16'h0781);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      acc(1, 1, 12'h802, tv[k], 1, 16'h0);
      acc(0, 1, 12'h802, 16'h0, 1, tv[k] & 16'h000A);
      check("scan_sel", o_scan_path_select, tv[k][3]);
      check("scan_en", o_test_scan_enable, tv[k][1]);
    end
    i_test_mode <= 1'b0;
    acc(1, 1, 12'h802, 16'hFFFF, 1, 16'h0);
    acc(0, 1, 12'h802, 16'h0, 1, 16'h0000);
    check("scan_en", o_test_scan_enable, 1'b0);
    $display("test scan done");
    i_irq_pending <= 1'b1;
    @(posedge i_clock);
    check("irq_level", o_irq_level, 3'h7);
    check("arb_req", o_arb_request, 4'hF);
    interrupt_acknowledge_cycle_run(4'h5, 1, 8'h80);
    acc(1, 1, 12'h800, 16'h6003, 1, 16'h0);
    interrupt_acknowledge_cycle_run(4'h5, 0, 8'h00);
    acc(1, 1, 12'h804, 16'h0081, 1, 16'h0);
    check("irq_level", o_irq_level, 3'h0);
    check("arb_req", o_arb_request, 4'h0);
    interrupt_acknowledge_cycle_run(4'h0, 0, 8'h00);
    acc(1, 1, 12'h804, 16'h0781, 1, 16'h0);
    acc(1, 1, 12'h800, 16'h6000, 1, 16'h0);
    check("arb_req", o_arb_request, 4'h0);
    interrupt_acknowledge_cycle_run(4'h0, 0, 8'h00);
    $display("test interrupts done");
    i_freeze <= 1'b1;
    repeat (4) @(posedge i_clock);
    check("halt", o_freeze_halt, 1'b0);
    i_transfer_boundary <= 1'b1;
    repeat (2) @(posedge i_clock);
    check("halt", o_freeze_halt, 1'b1);
    check("irq_level", o_irq_level, 3'h7);
    i_freeze <= 1'b0;
    repeat (2) @(posedge i_clock);
    check("halt", o_freeze_halt, 1'b0);
    acc(1, 1, 12'h800, 16'h2000, 1, 16'h0);
    acc(0, 1, 12'h800, 16'h0, 1, 16'h0000);
    i_freeze <= 1'b1;
    repeat (4) @(posedge i_clock);
    check("halt", o_freeze_halt, 1'b0);
    i_freeze <= 1'b0;
    // Clock enable low: the write is acked but must not land
    i_enable <= 1'b0;
    acc(1, 1, 12'h804, 16'h0555, 1, 16'h0);
    i_enable <= 1'b1;
    acc(0, 1, 12'h804, 16'h0, 1, 16'h0781);
    $display("test freeze done");
    i_halt_acknowledge_flag <= 1'b1;
    acc(1, 1, 12'h800, 16'h8000, 1, 16'h0);
    check("stop", o_clock_gate_stop, 1'b1);
    acc(1, 1, 12'h804, 16'h0300, 1, 16'h0);
    acc(0, 1, 12'h804, 16'h0, 1, 16'h0000);
    acc(0, 1, 12'h800, 16'h0, 1, 16'h8000);
    acc(1, 1, 12'h800, 16'h0000, 1, 16'h0);
    check("stop", o_clock_gate_stop, 1'b0);
    acc(0, 1, 12'h804, 16'h0, 1, 16'h0301);
    acc(1, 1, 12'h800, 16'h8000, 1, 16'h0);
    check("stop", o_clock_gate_stop, 1'b1);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    acc(0, 1, 12'h800, 16'h0, 1, 16'h0080);
    check("stop", o_clock_gate_stop, 1'b0);
    $display("test stop done");
    end_sim();
  end
endmodule
